// ---- osc_pkg.sv ----
// Package: register map, field layout, states and frequency decode of the clock control
package osc_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STAT   = 12'h004;
    localparam logic [11:0] ADDR_TUNE   = 12'h008;

    // Reset values
    localparam logic [7:0]  CTRL_RESET  = 8'h38;
    localparam logic [5:0]  TUNE_RESET  = 6'h00;
    localparam logic [7:0]  STAT_RESET  = 8'h80;

    // Field positions
    localparam int          CTRL_PLL_BIT  = 7;
    localparam int          CTRL_IRCF_LSB = 3;
    localparam int          CTRL_SCS_LSB  = 0;
    localparam int          TUNE_W        = 6;

    // Source select and configured oscillator mode codes
    localparam logic [1:0]  SCS_CONFIG     = 2'h0;
    localparam logic [1:0]  SCS_SECOND     = 2'h1;
    localparam logic [2:0]  OSC_MODE_INTOSC = 3'h4;

    // Running clock and internal oscillator identifiers
    localparam logic [1:0]  SRC_INT = 2'h0;
    localparam logic [1:0]  SRC_SEC = 2'h1;
    localparam logic [1:0]  SRC_CFG = 2'h2;
    localparam logic [1:0]  OSC_HF  = 2'h0;
    localparam logic [1:0]  OSC_MF  = 2'h1;
    localparam logic [1:0]  OSC_LF  = 2'h2;

    // Start-up timer length in oscillator cycles
    localparam logic [10:0] OST_CYCLES = 11'h400;
    localparam logic [10:0] OST_LAST   = OST_CYCLES - 11'h001;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Clock source sequencer states
    typedef enum logic [3:0] {
        CS_INT  = 4'h1,
        CS_OST  = 4'h2,
        CS_EXT  = 4'h4,
        CS_FAIL = 4'h8
    } osc_clk_state_e;

    // Control register layout
    typedef struct packed {
        logic       pll_sw_enable;
        logic [3:0] int_freq_select;
        logic       rsvd;
        logic [1:0] sysclk_source_select;
    } osc_ctrl_s;

    // Status register layout
    typedef struct packed {
        logic sec_osc_ready;
        logic pll_ready;
        logic startup_timer_status;
        logic hf_osc_ready;
        logic hf_osc_locked;
        logic mf_osc_ready;
        logic lf_osc_ready;
        logic hf_osc_stable;
    } osc_stat_s;

    // Frequency select decode: {oscillator, frequency in Hz}
    function automatic logic [26:0] osc_decode(input logic [3:0] code, input logic pll);
        case (code)
            4'hf:    osc_decode = {OSC_HF, 25'd16000000};
            4'he:    osc_decode = pll ? {OSC_HF, 25'd32000000} : {OSC_HF, 25'd8000000};
            4'hd:    osc_decode = {OSC_HF, 25'd4000000};
            4'hc:    osc_decode = {OSC_HF, 25'd2000000};
            4'hb:    osc_decode = {OSC_HF, 25'd1000000};
            4'ha:    osc_decode = {OSC_HF, 25'd500000};
            4'h9:    osc_decode = {OSC_HF, 25'd250000};
            4'h8:    osc_decode = {OSC_HF, 25'd125000};
            4'h7:    osc_decode = {OSC_MF, 25'd500000};
            4'h6:    osc_decode = {OSC_MF, 25'd250000};
            4'h5:    osc_decode = {OSC_MF, 25'd125000};
            4'h4:    osc_decode = {OSC_MF, 25'd62500};
            4'h3:    osc_decode = {OSC_HF, 25'd31250};
            4'h2:    osc_decode = {OSC_MF, 25'd31250};
            default: osc_decode = {OSC_LF, 25'd31000};
        endcase
    endfunction

endpackage

// ---- osc_select_ctrl.sv ----
// Oscillator select, status and trim block with AXI4-Lite register access
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps

module osc_select_ctrl
    import osc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] awaddr,
    input  wire logic [2:0]  awprot,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic [2:0]  arprot,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        pll_config_force,
    input  wire logic [2:0]  config_osc_mode,
    input  wire logic        timer1_osc_enable,
    input  wire logic        sec_osc_ready_in,
    input  wire logic        pll_lock_in,
    input  wire logic        hf_ready_in,
    input  wire logic        hf_locked_in,
    input  wire logic        hf_stable_in,
    input  wire logic        mf_ready_in,
    input  wire logic        lf_ready_in,
    input  wire logic        ext_osc_tick,
    input  wire logic        ext_clk_fail,
    input  wire logic        osc_fail_clear,
    output logic             pll_enable,
    output logic [1:0]       int_osc_src,
    output logic [24:0]      int_freq_hz,
    output logic [1:0]       sysclk_sel,
    output logic [5:0]       freq_trim,
    output logic             startup_timer_status,
    output logic             osc_fail_flag
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    // Register select: 0 control, 1 status, 2 tuning, 3 unmapped
    function automatic logic [1:0] reg_sel(input logic [11:0] a);
        logic [11:0] w;
        w = {a[11:2], 2'h0};
        if (w == ADDR_CTRL)      reg_sel = 2'h0;
        else if (w == ADDR_STAT) reg_sel = 2'h1;
        else if (w == ADDR_TUNE) reg_sel = 2'h2;
        else                     reg_sel = 2'h3;
    endfunction

    // Whether a source select value needs the start-up timer
    function automatic logic needs_ext(input logic [1:0] scs, input logic [2:0] mode);
        needs_ext = (scs == SCS_SECOND) || (scs == SCS_CONFIG && mode != OSC_MODE_INTOSC);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State
    osc_ctrl_s      ctrl_r;
    osc_ctrl_s      ctrl_nxt;
    osc_stat_s      stat_r;
    osc_stat_s      stat_nxt;
    logic [5:0]     tune_r;
    osc_clk_state_e state_r;
    osc_clk_state_e state_nxt;
    logic [10:0]    cnt_r;
    logic [10:0]    cnt_nxt;
    logic           aw_got_r;
    logic           w_got_r;
    logic [11:0]    addr_r;
    logic [7:0]     data_r;
    logic           strb_r;

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    wire         aw_hs      = awvalid & awready;
    wire         w_hs       = wvalid & wready;
    wire         aw_have    = aw_got_r | aw_hs;
    wire         w_have     = w_got_r | w_hs;
    wire         do_wr      = aw_have & w_have & ~bvalid;
    wire [11:0]  wr_addr    = aw_hs ? awaddr : addr_r;
    wire [7:0]   wr_data    = w_hs ? wdata[7:0] : data_r;
    wire         wr_strb    = w_hs ? wstrb[0] : strb_r;
    wire [1:0]   wr_sel     = reg_sel(wr_addr);
    wire         bvalid_nxt = do_wr | (bvalid & ~bready);
    wire         aw_got_nxt = aw_have & ~do_wr;
    wire         w_got_nxt  = w_have & ~do_wr;
    wire         wr_ctrl    = do_wr & wr_strb & (wr_sel == 2'h0);
    wire         wr_tune    = do_wr & wr_strb & (wr_sel == 2'h2);

    // Reserved bit forced to zero on every write
    assign ctrl_nxt = wr_ctrl ? osc_ctrl_s'({wr_data[7:3], 1'b0, wr_data[1:0]}) : ctrl_r;
    wire   scs_chg  = wr_ctrl && (wr_data[1:0] != ctrl_r.sysclk_source_select);

    // Address and data held until both halves of a write are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            addr_r   <= 12'h000;
            data_r   <= 8'h00;
            strb_r   <= 1'b0;
            awready  <= 1'b0;
            wready   <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= RESP_OKAY;
        end else begin
            aw_got_r <= aw_got_nxt;
            w_got_r  <= w_got_nxt;
            if (aw_hs) addr_r <= awaddr;
            if (w_hs) begin
                data_r <= wdata[7:0];
                strb_r <= wstrb[0];
            end
            awready  <= ~aw_got_nxt & ~bvalid_nxt;
            wready   <= ~w_got_nxt & ~bvalid_nxt;
            bvalid   <= bvalid_nxt;
            // Status writes answer OKAY but store nothing
            if (do_wr) bresp <= (wr_sel == 2'h3) ? RESP_SLVERR : RESP_OKAY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    wire        ar_hs      = arvalid & arready;
    wire        rvalid_nxt = ar_hs | (rvalid & ~rready);
    wire [1:0]  rd_sel     = reg_sel(araddr);
    wire [7:0]  rd_byte    = (rd_sel == 2'h0) ? ctrl_r :
                             (rd_sel == 2'h1) ? stat_r :
                             (rd_sel == 2'h2) ? {2'h0, tune_r} : 8'h00;

    // Read data captured at the address handshake, held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else begin
            arready <= ~rvalid_nxt;
            rvalid  <= rvalid_nxt;
            if (ar_hs) begin
                rdata <= {24'h00_0000, rd_byte};
                rresp <= (rd_sel == 2'h3) ? RESP_SLVERR : RESP_OKAY;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock source sequencer
    wire ext_wanted = needs_ext(ctrl_r.sysclk_source_select, config_osc_mode);
    wire new_ext    = needs_ext(wr_data[1:0], config_osc_mode);
    wire ost_done   = ext_osc_tick && (cnt_r == OST_LAST);

    // A select change to an external source restarts the timer, even out of fail-safe; any other select goes to internal
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        if (scs_chg) begin
            state_nxt = new_ext ? CS_OST : CS_INT;
            cnt_nxt   = 11'h000;
        end else begin
            case (state_r)
                CS_OST: begin
                    if (!ext_wanted) begin
                        state_nxt = CS_INT;
                    end else if (ost_done) begin
                        state_nxt = CS_EXT;
                    end else if (ext_osc_tick) begin
                        cnt_nxt = cnt_r + 11'h001;
                    end
                end
                CS_EXT: begin
                    if (ext_clk_fail) state_nxt = CS_FAIL;
                end
                CS_INT:  state_nxt = CS_INT;
                CS_FAIL: state_nxt = CS_FAIL;
                default: state_nxt = CS_INT;
            endcase
        end
    end

    // Running clock: internal block unless the external source is in use
    wire [1:0] sel_nxt = (state_nxt != CS_EXT) ? SRC_INT :
                         (ctrl_nxt.sysclk_source_select == SCS_SECOND) ? SRC_SEC :
                         SRC_CFG;
    wire [26:0] dec_nxt  = osc_decode(ctrl_nxt.int_freq_select, ctrl_nxt.pll_sw_enable);
    wire        fail_set = (state_r == CS_EXT) && ext_clk_fail && !scs_chg;

    // Live status sampled each cycle
    assign stat_nxt = '{
        sec_osc_ready:        timer1_osc_enable ? sec_osc_ready_in : 1'b1,
        pll_ready:            pll_lock_in,
        startup_timer_status: (sel_nxt == SRC_CFG),
        hf_osc_ready:         hf_ready_in,
        hf_osc_locked:        hf_locked_in,
        mf_osc_ready:         mf_ready_in,
        lf_osc_ready:         lf_ready_in,
        hf_osc_stable:        hf_stable_in
    };

    // Registers and registered outputs; reset starts the power-on timer run
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r               <= osc_ctrl_s'(CTRL_RESET);
            tune_r               <= TUNE_RESET;
            stat_r               <= osc_stat_s'(STAT_RESET);
            state_r              <= CS_OST;
            cnt_r                <= 11'h000;
            pll_enable           <= 1'b0;
            int_osc_src          <= OSC_MF;
            int_freq_hz          <= 25'd500000;
            sysclk_sel           <= SRC_INT;
            freq_trim            <= TUNE_RESET;
            startup_timer_status <= 1'b0;
            osc_fail_flag        <= 1'b0;
        end else begin
            ctrl_r               <= ctrl_nxt;
            if (wr_tune) tune_r  <= wr_data[5:0];
            stat_r               <= stat_nxt;
            state_r              <= state_nxt;
            cnt_r                <= cnt_nxt;
            pll_enable           <= pll_config_force | ctrl_nxt.pll_sw_enable;
            {int_osc_src, int_freq_hz} <= dec_nxt;
            sysclk_sel           <= sel_nxt;
            freq_trim            <= wr_tune ? wr_data[5:0] : tune_r;
            startup_timer_status <= stat_nxt.startup_timer_status;
            // Set wins over a clear in the same cycle
            osc_fail_flag        <= fail_set | (osc_fail_flag & ~osc_fail_clear);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_pll_force;
        @(posedge aclk) disable iff (!aresetn)
        pll_config_force |=> pll_enable;
    endproperty
    a_pll_force: assert property (p_pll_force) else $error("PLL off while forced");

    property p_pll_sw;
        @(posedge aclk) disable iff (!aresetn)
        (!pll_config_force && !ctrl_nxt.pll_sw_enable) |=> !pll_enable;
    endproperty
    a_pll_sw: assert property (p_pll_sw) else $error("PLL on without enable");

    property p_freq_32m;
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_r.int_freq_select == 4'he && ctrl_r.pll_sw_enable && !wr_ctrl)
            |=> int_freq_hz == 25'd32000000;
    endproperty
    a_freq_32m: assert property (p_freq_32m) else $error("Code 1110 not 32 MHz");

    property p_reset_freq;
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> int_freq_hz == 25'd500000 && int_osc_src == OSC_MF;
    endproperty
    a_reset_freq: assert property (p_reset_freq) else $error("Reset not 500 kHz MF");

    property p_lf_code;
        @(posedge aclk) disable iff (!aresetn)
        (ctrl_nxt.int_freq_select[3:1] == 3'h0) |=> int_osc_src == OSC_LF
            && int_freq_hz == 25'd31000;
    endproperty
    a_lf_code: assert property (p_lf_code) else $error("Code 000x not 31 kHz LF");

    property p_scs_int;
        @(posedge aclk) disable iff (!aresetn)
        ctrl_r.sysclk_source_select[1] |-> sysclk_sel == SRC_INT;
    endproperty
    a_scs_int: assert property (p_scs_int) else $error("Select 1x not internal");

    property p_sec_ready;
        @(posedge aclk) disable iff (!aresetn)
        !timer1_osc_enable |=> stat_r.sec_osc_ready;
    endproperty
    a_sec_ready: assert property (p_sec_ready) else $error("Secondary ready not 1");

    property p_ost_len;
        @(posedge aclk) disable iff (!aresetn)
        (state_r == CS_OST && state_nxt == CS_EXT) |-> cnt_r == OST_LAST && ext_osc_tick;
    endproperty
    a_ost_len: assert property (p_ost_len) else $error("Timer switched early");

    property p_scs_restart;
        @(posedge aclk) disable iff (!aresetn)
        scs_chg |=> cnt_r == 11'h000 && sysclk_sel == SRC_INT;
    endproperty
    a_scs_restart: assert property (p_scs_restart) else $error("No timer restart");

    property p_fail;
        @(posedge aclk) disable iff (!aresetn)
        fail_set |=> osc_fail_flag && sysclk_sel == SRC_INT && !startup_timer_status;
    endproperty
    a_fail: assert property (p_fail) else $error("Failure not handled");

    property p_status_ext;
        @(posedge aclk) disable iff (!aresetn)
        startup_timer_status |-> state_r == CS_EXT && sysclk_sel == SRC_CFG;
    endproperty
    a_status_ext: assert property (p_status_ext) else $error("Status without external");

    c_ost_done: cover property (@(posedge aclk) disable iff (!aresetn)
        state_r == CS_OST ##1 state_r == CS_EXT);
    c_fail: cover property (@(posedge aclk) disable iff (!aresetn) $rose(osc_fail_flag));
    c_32m: cover property (@(posedge aclk) disable iff (!aresetn)
        int_freq_hz == 25'd32000000);
    c_read: cover property (@(posedge aclk) disable iff (!aresetn) rvalid && rready);

endmodule // osc_select_ctrl

// ---- osc_select_ctrl_tb_top.sv ----
// Self-checking testbench for the oscillator select, status and trim block
`timescale 1ns/1ps
module osc_select_ctrl_tb_top
    import osc_pkg::*;
;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, pll_config_force, timer1_osc_enable;
    logic        sec_osc_ready_in, pll_lock_in, hf_ready_in, hf_locked_in, hf_stable_in;
    logic        mf_ready_in, lf_ready_in, ext_osc_tick, ext_clk_fail, osc_fail_clear;
    logic        pll_enable, startup_timer_status, osc_fail_flag;
    logic [11:0] awaddr, araddr;
    logic [2:0]  awprot, arprot, config_osc_mode;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, int_osc_src, sysclk_sel, rsp;
    logic [24:0] int_freq_hz;
    logic [5:0]  freq_trim;
    int          error_cnt, cmp_count, i;
    // Rows: {pll enable, select code, expected oscillator, expected frequency}
    localparam logic [31:0] ROWS [17] = '{
        {1'b0, 4'hf, OSC_HF, 25'h0f42400}, {1'b0, 4'he, OSC_HF, 25'h07a1200},
        {1'b1, 4'he, OSC_HF, 25'h1e84800}, {1'b0, 4'hd, OSC_HF, 25'h03d0900},
        {1'b0, 4'hc, OSC_HF, 25'h01e8480}, {1'b0, 4'hb, OSC_HF, 25'h00f4240},
        {1'b0, 4'ha, OSC_HF, 25'h007a120}, {1'b0, 4'h9, OSC_HF, 25'h003d090},
        {1'b0, 4'h8, OSC_HF, 25'h001e848}, {1'b0, 4'h7, OSC_MF, 25'h007a120},
        {1'b0, 4'h6, OSC_MF, 25'h003d090}, {1'b0, 4'h5, OSC_MF, 25'h001e848},
        {1'b0, 4'h4, OSC_MF, 25'h000f424}, {1'b0, 4'h3, OSC_HF, 25'h0007a12},
        {1'b0, 4'h2, OSC_MF, 25'h0007a12}, {1'b1, 4'h1, OSC_LF, 25'h0007918},
        {1'b0, 4'h0, OSC_LF, 25'h0007918}};
    // Status inputs {t1 en, sec, pll, hf rdy, lock, mf, lf, stable} and the status they give
    localparam logic [7:0] ST_IN [3]  = '{8'h33, 8'h8c, 8'hc0};
    localparam logic [7:0] ST_EXP [3] = '{8'hd3, 8'h0c, 8'h80};

    osc_select_ctrl u_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pll_config_force(pll_config_force), .config_osc_mode(config_osc_mode),
        .timer1_osc_enable(timer1_osc_enable), .sec_osc_ready_in(sec_osc_ready_in),
        .pll_lock_in(pll_lock_in), .hf_ready_in(hf_ready_in), .hf_locked_in(hf_locked_in),
        .hf_stable_in(hf_stable_in), .mf_ready_in(mf_ready_in), .lf_ready_in(lf_ready_in),
        .ext_osc_tick(ext_osc_tick), .ext_clk_fail(ext_clk_fail),
        .osc_fail_clear(osc_fail_clear), .pll_enable(pll_enable), .int_osc_src(int_osc_src),
        .int_freq_hz(int_freq_hz), .sysclk_sel(sysclk_sel), .freq_trim(freq_trim),
        .startup_timer_status(startup_timer_status), .osc_fail_flag(osc_fail_flag));

    ////////////////////////////////////////////////////////////////////////////////
    // 100 MHz clock
    always #5 aclk = ~aclk;

    ////////////////////////////////////////////////////////////////////////////////
    // Compare, report and close
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic hang();
        error_cnt++;
        $display("unexpected at %0t: bus answer never came", $time);
        give_verdict();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Bus master: ready lines stay high, so each answer is taken at its first edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
        int n;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h000000, d};
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rsp = bresp;
        if (n == 64) hang();
    endtask

    task automatic rdr(input logic [11:0] a);
        int n;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd  = rdata;
        rsp = rresp;
        if (n == 64) hang();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reset, settling and oscillator tick helpers
    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    task automatic settle();
        repeat (2) @(posedge aclk);
        #1;
    endtask

    // Ticks are spaced out so each one is a clean single-cycle pulse
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge aclk);
            ext_osc_tick <= 1'b1;
            @(posedge aclk);
            ext_osc_tick <= 1'b0;
        end
        settle();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {aclk, aresetn, awvalid, wvalid, arvalid, pll_config_force, ext_osc_tick} = '0;
        {timer1_osc_enable, sec_osc_ready_in, pll_lock_in, hf_ready_in} = '0;
        {hf_locked_in, hf_stable_in, mf_ready_in, lf_ready_in, ext_clk_fail} = '0;
        {awaddr, araddr, awprot, arprot, wdata, wstrb, osc_fail_clear} = '0;
        {bready, rready} = 2'b11;
        config_osc_mode = OSC_MODE_INTOSC;
        error_cnt = 0;
        cmp_count = 0;
        do_reset();
        settle();
        chk(32'(int_freq_hz), 32'h0007a120);
        chk(32'(int_osc_src), 32'(OSC_MF));
        rdr(ADDR_CTRL);
        chk(rd, 32'h00000038);
        rdr(ADDR_STAT);
        chk(rd, 32'h00000080);
        rdr(ADDR_TUNE);
        chk(rd, 32'h00000000);
        $display("test reset values done");
        // Every select code, bit 2 written high, select bits 10 and 11 in turn
        for (i = 0; i < 17; i++) begin
            wr(ADDR_CTRL, {ROWS[i][31:27], 2'b11, i[0]}, 4'h1);
            rdr(ADDR_CTRL);
            chk(rd, {24'h000000, ROWS[i][31:27], 2'b01, i[0]});
            chk(32'(int_osc_src), 32'(ROWS[i][26:25]));
            chk(32'(int_freq_hz), 32'(ROWS[i][24:0]));
            chk(32'(pll_enable), 32'(ROWS[i][31]));
            chk(32'(sysclk_sel), 32'(SRC_INT));
        end
        @(posedge aclk);
        pll_config_force <= 1'b1;
        settle();
        chk(32'(pll_enable), 32'h1);
        @(posedge aclk);
        pll_config_force <= 1'b0;
        $display("test select table done");
        // Live status flags; a write to status must change nothing
        for (i = 0; i < 3; i++) begin
            @(posedge aclk);
            {timer1_osc_enable, sec_osc_ready_in, pll_lock_in, hf_ready_in,
             hf_locked_in, mf_ready_in, lf_ready_in, hf_stable_in} <= ST_IN[i];
            settle();
            rdr(ADDR_STAT);
            chk(rd, {24'h000000, ST_EXP[i]});
        end
        wr(ADDR_STAT, 8'h00, 4'h1);
        chk(32'(rsp), 32'(RESP_OKAY));
        rdr(ADDR_STAT);
        chk(rd, 32'h00000080);
        $display("test status done");
        // Trim extremes, upper bits dropped, ignored strobe, unmapped place
        wr(ADDR_TUNE, 8'he0, 4'h1);
        rdr(ADDR_TUNE);
        chk(rd, 32'h00000020);
        chk(32'(freq_trim), 32'h20);
        wr(ADDR_TUNE, 8'h5f, 4'h1);
        wr(ADDR_TUNE, 8'h00, 4'h0);
        rdr(ADDR_TUNE);
        chk(rd, 32'h0000001f);
        chk(32'(rsp), 32'(RESP_OKAY));
        chk(32'(freq_trim), 32'h1f);
        wr(12'h00c, 8'h11, 4'h1);
        chk(32'(rsp), 32'(RESP_SLVERR));
        rdr(12'h00c);
        chk(rd, 32'h00000000);
        chk(32'(rsp), 32'(RESP_SLVERR));
        $display("test trim and decode done");
        // Secondary, then configured external clock, each after the full count
        @(posedge aclk);
        config_osc_mode <= 3'h0;
        wr(ADDR_CTRL, 8'h39, 4'h1);
        ticks(1023);
        chk(32'(sysclk_sel), 32'(SRC_INT));
        ticks(1);
        chk(32'(sysclk_sel), 32'(SRC_SEC));
        chk(32'(startup_timer_status), 32'h0);
        wr(ADDR_CTRL, 8'h38, 4'h1);
        ticks(1023);
        chk(32'(sysclk_sel), 32'(SRC_INT));
        ticks(1);
        chk({30'h0, sysclk_sel}, 32'(SRC_CFG));
        rdr(ADDR_STAT);
        chk(32'(rd[5]), 32'h1);
        chk(32'(startup_timer_status), 32'h1);
        $display("test start-up timer done");
        // Clock failure falls back to internal and stays there
        // Clear raised together with the failure: the set must win
        @(posedge aclk);
        ext_clk_fail   <= 1'b1;
        osc_fail_clear <= 1'b1;
        @(posedge aclk);
        ext_clk_fail   <= 1'b0;
        osc_fail_clear <= 1'b0;
        #1;
        chk({osc_fail_flag, startup_timer_status, sysclk_sel}, {2'b10, SRC_INT});
        ticks(2);
        chk(32'(sysclk_sel), 32'(SRC_INT));
        @(posedge aclk);
        osc_fail_clear <= 1'b1;
        @(posedge aclk);
        osc_fail_clear <= 1'b0;
        settle();
        chk(32'(osc_fail_flag), 32'h0);
        $display("test fail-safe done");
        // Second reset in mid-run; control first moved off its reset value
        wr(ADDR_CTRL, 8'hfa, 4'h1);
        chk(32'(pll_enable), 32'h1);
        do_reset();
        settle();
        chk({pll_enable, int_osc_src, int_freq_hz}, {1'b0, OSC_MF, 25'd500000});
        rdr(ADDR_CTRL);
        chk(rd, 32'h00000038);
        rdr(ADDR_TUNE);
        chk(rd, 32'h00000000);
        // External mode still configured, so reset starts a power-on timer run
        chk(32'(sysclk_sel), 32'(SRC_INT));
        ticks(1024);
        chk(32'(sysclk_sel), 32'(SRC_CFG));
        $display("test second reset done");
        give_verdict();
    end

endmodule // osc_select_ctrl_tb_top
